/* rtl/wake_seq_consts.svh */
`ifndef WAKE_SEQ_CONSTS_SVH
`define WAKE_SEQ_CONSTS_SVH

// =====================================================================
// timing
`define CLK_PERIOD_NS 20
`define OSC_FREQ_HZ 10000
`define OSC_DIV_CYCLES (1000000000 / (`OSC_FREQ_HZ * `CLK_PERIOD_NS))
`define CONV_PRESCALE 6'h3F
`define RTC_PERIOD_MS 10
`define RTC_OSC_TICKS ((`RTC_PERIOD_MS * `OSC_FREQ_HZ) / 1000)

// =====================================================================
// processor entry points
`define ROM_ENTRY_ADDR 12'h800
`define USER_ENTRY_ADDR 12'h030

// =====================================================================
// watchdog
`define WDT_LIMIT 3'h4

// =====================================================================
// status word 22 bit positions
`define STAT_WDT_ALARM_BIT 17
`define STAT_BUTTON_BIT 18
`define STAT_SLEEP_WAKE_BIT 22

// =====================================================================
// reset values
`define CONV_RESET 10'h001
`define STATUS_RESET 24'h000000

`endif

/* rtl/wake_seq_pkg.sv */
package wake_seq_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ROM,
		ST_CHECK,
		ST_AUTO_CFG,
		ST_DECIDE,
		ST_USER,
		ST_STOP
	} seq_state_e;

	typedef struct packed {
		seq_state_e st;
		logic [12:0] osc_div;
		logic [5:0] pre;
		logic [9:0] conv;
		logic [6:0] rtc_div;
		logic [23:0] rtc;
		logic [2:0] wdt;
		logic wdt_en;
		logic rst_pend;
		logic meas_pend;
		logic conv_pend;
		logic from_reset;
		logic from_sleep;
		logic wdt_alarm;
		logic btn_prev;
		logic cpu_run;
		logic pc_load;
		logic [11:0] pc;
		logic cpu_clear;
		logic cfg_req;
		logic meas_start;
		logic chip_reset;
		logic osc_tick;
		logic [23:0] status;
	} seq_s;
endpackage

/* rtl/pin_sync.sv */
module pin_sync (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic pin_in,
	output logic level_out
);
	// reset value is the idle (released) level of an active-low pin
	logic [2:0] sync;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			sync <= 3'h7;
			level_out <= 1'b1;
		end else begin
			sync <= {sync[1:0], pin_in};
			// a change counts only once the second and third stage agree
			if (sync[1] == sync[2]) begin
				level_out <= sync[2];
			end
		end
	end
endmodule

/* rtl/wake_reset_watchdog_sequencer.sv */
// Contract
// - wake on reset, measurement end or sleep counter expiry; reset wins.
// - every activation starts the processor at rom address 2048.
// - after reset, request auto-configuration copy when the config flag is set.
// - after reset, jump to user code at 48 if program flag set, else halt.
// - non-reset wake starts measurement or restarts counter; user flag gates jump.
// - processor stop clears processor state and stack, ram untouched.
// - power-on reset resets whole chip except ram, then user code may start.
// - four starts without watchdog clear raise a power-on reset.
// - watchdog timeout shows in status bit 17 of register 22.
// - with host port disabled, chip-select pin acts as external reset.
// - button state shows in status bit 18 of register 22.
// - in sleep only the slow oscillator runs; periodic wakes without measuring.
// - wake from sleep shows in status bit 22 of register 22.
// - sleep selected by config bit or zero averaging rate, same behaviour.
// - in sleep the counter runs to end and then starts user code.
// - the 10 kHz oscillator is the base clock for conversions and cycles.
// - conversions start at 10 kHz / 64 / counter setting, counter runs freely.
// - watchdog counts each measurement start; user code must clear it.
// - host command may disable watchdog; every pin edge clears it.
// - 24-bit real-time counter steps every 10 ms, cleared by instruction.
`include "wake_seq_consts.svh"

module wake_reset_watchdog_sequencer #(
	parameter int OSC_DIV_CYCLES = `OSC_DIV_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic chip_select_reset_pin_in,
	input wire logic host_port_enable_in,
	input wire logic sleep_mode_in,
	input wire logic avrate_zero_in,
	input wire logic [9:0] conv_count_in,
	input wire logic pwr_cfg_flag_in,
	input wire logic pwr_prg_flag_in,
	input wire logic usr_prg_flag_in,
	input wire logic cfg_copy_done_in,
	input wire logic meas_done_in,
	input wire logic cpu_halt_in,
	input wire logic clrwdt_in,
	input wire logic watchdog_off_cmd_in,
	input wire logic timer_clear_instr_in,
	output logic cpu_run_out,
	output logic cpu_pc_load_out,
	output logic [11:0] cpu_pc_out,
	output logic cpu_clear_out,
	output logic cfg_copy_req_out,
	output logic meas_start_out,
	output logic chip_reset_out,
	output logic osc_tick_out,
	output logic activated_by_reset_out,
	output logic sleep_wake_flag_out,
	output logic [2:0] wdt_count_out,
	output logic [23:0] rtc_out,
	output logic [23:0] status_out
);
	import wake_seq_pkg::*;

	// =================================================================
	// state
	seq_s s;
	seq_s next_s;
	logic btn_level;
	logic sleep_active;
	logic conv_expire;
	logic rtc_step;
	logic wdt_inc;
	logic wdt_trip;
	logic pin_edge;
	logic ext_reset;

	localparam logic [12:0] OSC_LAST = 13'(OSC_DIV_CYCLES - 1);
	localparam logic [6:0] RTC_LAST = 7'(`RTC_OSC_TICKS - 1);

	// =================================================================
	// pin conditioning
	pin_sync u_pin_sync (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.pin_in(chip_select_reset_pin_in),
		.level_out(btn_level)
	);

	// =================================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.pc_load = 1'b0;
		next_s.cpu_clear = 1'b0;
		next_s.meas_start = 1'b0;
		next_s.chip_reset = 1'b0;
		next_s.osc_tick = 1'b0;
		conv_expire = 1'b0;
		rtc_step = 1'b0;
		wdt_inc = 1'b0;
		sleep_active = sleep_mode_in | avrate_zero_in;

		// slow oscillator tick derived from the system clock
		if (s.osc_div == OSC_LAST) begin
			next_s.osc_div = 13'h0000;
			next_s.osc_tick = 1'b1;
		end else begin
			next_s.osc_div = s.osc_div + 13'h0001;
		end

		// conversion counter: 64-step prescale, then reload count
		if (s.osc_tick) begin
			if (s.pre == `CONV_PRESCALE) begin
				next_s.pre = 6'h00;
				if (s.conv <= 10'h001) begin
					next_s.conv = conv_count_in;
					conv_expire = 1'b1;
				end else begin
					next_s.conv = s.conv - 10'h001;
				end
			end else begin
				next_s.pre = s.pre + 6'h01;
			end
			if (s.rtc_div == RTC_LAST) begin
				next_s.rtc_div = 7'h00;
				rtc_step = 1'b1;
			end else begin
				next_s.rtc_div = s.rtc_div + 7'h01;
			end
		end

		// real-time counter wraps naturally at 24 bits
		if (timer_clear_instr_in) begin
			next_s.rtc = 24'h000000;
			next_s.rtc_div = 7'h00;
		end else if (rtc_step) begin
			next_s.rtc = s.rtc + 24'h000001;
		end

		// =============================================================
		// activation sequence
		case (s.st)
			ST_IDLE: begin
				if (s.rst_pend) begin
					next_s.rst_pend = 1'b0;
					next_s.from_reset = 1'b1;
					next_s.from_sleep = 1'b0;
					next_s.st = ST_ROM;
				end else if (s.meas_pend) begin
					next_s.meas_pend = 1'b0;
					next_s.from_reset = 1'b0;
					next_s.from_sleep = 1'b0;
					next_s.st = ST_ROM;
				end else if (s.conv_pend) begin
					next_s.conv_pend = 1'b0;
					next_s.from_reset = 1'b0;
					next_s.from_sleep = 1'b1;
					next_s.st = ST_ROM;
				end
			end
			ST_ROM: begin
				next_s.cpu_run = 1'b1;
				next_s.pc_load = 1'b1;
				next_s.pc = `ROM_ENTRY_ADDR;
				next_s.st = ST_CHECK;
			end
			ST_CHECK: begin
				if (s.from_reset) begin
					if (pwr_cfg_flag_in) begin
						next_s.cfg_req = 1'b1;
						next_s.st = ST_AUTO_CFG;
					end else begin
						next_s.st = ST_DECIDE;
					end
				end else begin
					// sleep wakes restart the counter instead of measuring
					if (s.from_sleep) begin
						next_s.conv = conv_count_in;
						next_s.pre = 6'h00;
					end else begin
						next_s.meas_start = 1'b1;
					end
					wdt_inc = 1'b1;
					next_s.st = ST_DECIDE;
				end
			end
			ST_AUTO_CFG: begin
				if (cfg_copy_done_in) begin
					next_s.cfg_req = 1'b0;
					next_s.st = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				if (s.from_reset ? pwr_prg_flag_in : usr_prg_flag_in) begin
					next_s.pc_load = 1'b1;
					next_s.pc = `USER_ENTRY_ADDR;
					next_s.st = ST_USER;
				end else begin
					next_s.st = ST_STOP;
				end
			end
			ST_USER: begin
				if (cpu_halt_in) begin
					next_s.st = ST_STOP;
				end
			end
			ST_STOP: begin
				// only processor state is cleared; ram is outside this block
				next_s.cpu_run = 1'b0;
				next_s.cpu_clear = 1'b1;
				next_s.pc = `ROM_ENTRY_ADDR;
				next_s.st = ST_IDLE;
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase

		// =============================================================
		// event sources; sets come after the sequence clears so they win
		if (meas_done_in) begin
			next_s.meas_pend = 1'b1;
		end
		if (conv_expire) begin
			if (sleep_active) begin
				next_s.conv_pend = 1'b1;
			end else begin
				next_s.meas_start = 1'b1;
				wdt_inc = 1'b1;
			end
		end

		// =============================================================
		// watchdog
		pin_edge = btn_level != s.btn_prev;
		next_s.btn_prev = btn_level;
		if (host_port_enable_in && watchdog_off_cmd_in) begin
			next_s.wdt_en = 1'b0;
		end
		if (clrwdt_in || pin_edge) begin
			next_s.wdt = 3'h0;
		end else if (wdt_inc && s.wdt < `WDT_LIMIT) begin
			next_s.wdt = s.wdt + 3'h1;
		end
		wdt_trip = s.wdt_en && (s.wdt == `WDT_LIMIT);

		// button pressed pulls the active-low pin low
		ext_reset = !host_port_enable_in && s.btn_prev && !btn_level;

		if (wdt_trip || ext_reset) begin
			// chip-wide reset; pending wakes are dropped, reset wake kept
			next_s.chip_reset = 1'b1;
			next_s.wdt = 3'h0;
			next_s.wdt_en = 1'b1;
			next_s.rst_pend = 1'b1;
			next_s.meas_pend = 1'b0;
			next_s.conv_pend = 1'b0;
			next_s.meas_start = 1'b0;
			next_s.cfg_req = 1'b0;
			next_s.cpu_run = 1'b0;
			next_s.cpu_clear = 1'b1;
			next_s.pc_load = 1'b0;
			next_s.pc = `ROM_ENTRY_ADDR;
			next_s.rtc = 24'h000000;
			next_s.rtc_div = 7'h00;
			next_s.st = ST_IDLE;
		end
		if (wdt_trip) begin
			next_s.wdt_alarm = 1'b1;
		end else if (ext_reset) begin
			next_s.wdt_alarm = 1'b0;
		end

		// =============================================================
		// status word 22
		next_s.status = `STATUS_RESET;
		next_s.status[`STAT_WDT_ALARM_BIT] = next_s.wdt_alarm;
		next_s.status[`STAT_BUTTON_BIT] = !btn_level;
		next_s.status[`STAT_SLEEP_WAKE_BIT] = next_s.from_sleep;
	end

	// =================================================================
	// registers
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s.st <= ST_IDLE;
			s.osc_div <= 13'h0000;
			s.pre <= 6'h00;
			s.conv <= `CONV_RESET;
			s.rtc_div <= 7'h00;
			s.rtc <= 24'h000000;
			s.wdt <= 3'h0;
			s.wdt_en <= 1'b1;
			s.rst_pend <= 1'b1;
			s.meas_pend <= 1'b0;
			s.conv_pend <= 1'b0;
			s.from_reset <= 1'b0;
			s.from_sleep <= 1'b0;
			s.wdt_alarm <= 1'b0;
			s.btn_prev <= 1'b1;
			s.cpu_run <= 1'b0;
			s.pc_load <= 1'b0;
			s.pc <= `ROM_ENTRY_ADDR;
			s.cpu_clear <= 1'b0;
			s.cfg_req <= 1'b0;
			s.meas_start <= 1'b0;
			s.chip_reset <= 1'b0;
			s.osc_tick <= 1'b0;
			s.status <= `STATUS_RESET;
		end else begin
			s <= next_s;
		end
	end

	// =================================================================
	// outputs, all straight from the state register
	assign cpu_run_out = s.cpu_run;
	assign cpu_pc_load_out = s.pc_load;
	assign cpu_pc_out = s.pc;
	assign cpu_clear_out = s.cpu_clear;
	assign cfg_copy_req_out = s.cfg_req;
	assign meas_start_out = s.meas_start;
	assign chip_reset_out = s.chip_reset;
	assign osc_tick_out = s.osc_tick;
	assign activated_by_reset_out = s.from_reset;
	assign sleep_wake_flag_out = s.from_sleep;
	assign wdt_count_out = s.wdt;
	assign rtc_out = s.rtc;
	assign status_out = s.status;
endmodule

/* sim/wake_seq_monitor.sv */
module wake_seq_monitor (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic host_port_enable_in,
	input wire logic pwr_cfg_flag_in,
	input wire logic pwr_prg_flag_in,
	input wire logic usr_prg_flag_in,
	input wire logic cfg_copy_done_in,
	input wire logic cpu_halt_in,
	input wire logic watchdog_off_cmd_in,
	input wire logic cpu_run_out,
	input wire logic cpu_pc_load_out,
	input wire logic [11:0] cpu_pc_out,
	input wire logic cpu_clear_out,
	input wire logic cfg_copy_req_out,
	input wire logic meas_start_out,
	input wire logic chip_reset_out,
	input wire logic activated_by_reset_out,
	input wire logic sleep_wake_flag_out,
	input wire logic [2:0] wdt_count_out,
	input wire logic [23:0] rtc_out,
	input wire logic [23:0] status_out
);
	logic wdt_off;

	// once the host switches the watchdog off, a count of four no longer fires
	always_ff @(posedge clk_sys_in) begin
		if (rst_in)
			wdt_off <= 1'b0;
		// a chip reset switches the watchdog back on
		else if (chip_reset_out)
			wdt_off <= 1'b0;
		else if (watchdog_off_cmd_in && host_port_enable_in)
			wdt_off <= 1'b1;
	end

	// ==========
	// assertions
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	AST_RUN_ROM: assert property ($rose(cpu_run_out) |->
		cpu_pc_load_out && cpu_pc_out == 12'h800) else $error("start not at rom entry");
	AST_RST_USER: assert property (cpu_pc_load_out && cpu_pc_out == 12'h030
		&& activated_by_reset_out |-> pwr_prg_flag_in) else $error("user start w/o flag");
	AST_WAKE_USER: assert property (cpu_pc_load_out && cpu_pc_out == 12'h030
		&& !activated_by_reset_out |-> usr_prg_flag_in) else $error("wake user w/o flag");
	AST_CFG_SRC: assert property ($rose(cfg_copy_req_out) |->
		activated_by_reset_out && pwr_cfg_flag_in) else $error("copy w/o reset and flag");
	AST_CFG_END: assert property (cfg_copy_req_out && cfg_copy_done_in |=>
		!cfg_copy_req_out) else $error("copy request held after done");
	// halt moves the sequence to the stop state, which clears one edge later
	AST_HALT: assert property (cpu_run_out && cpu_halt_in |-> ##2
		(!cpu_run_out && cpu_clear_out)) else $error("stop did not clear processor");
	AST_WDT_FIRE: assert property (wdt_count_out == 3'h4 && !wdt_off |=>
		chip_reset_out && status_out[17]) else $error("watchdog did not fire");
	AST_WDT_ZERO: assert property (chip_reset_out |->
		wdt_count_out == 3'h0) else $error("watchdog not cleared by reset");
	AST_SLEEP_NO_MEAS: assert property (sleep_wake_flag_out && cpu_run_out |->
		!meas_start_out) else $error("measurement in sleep wake");
	AST_RTC_STEP: assert property ($changed(rtc_out) |->
		rtc_out == $past(rtc_out) + 24'h1 || rtc_out == 24'h0) else $error("rtc jump");

	COV_USER: cover property (cpu_pc_load_out && cpu_pc_out == 12'h030);
	COV_WDT: cover property (chip_reset_out && status_out[17]);
	COV_SLEEP: cover property (sleep_wake_flag_out && cpu_run_out);
endmodule

bind wake_reset_watchdog_sequencer wake_seq_monitor mon (.clk_sys_in, .rst_in,
	.host_port_enable_in, .pwr_cfg_flag_in, .pwr_prg_flag_in, .usr_prg_flag_in,
	.cfg_copy_done_in, .cpu_halt_in, .watchdog_off_cmd_in, .cpu_run_out, .cpu_pc_load_out,
	.cpu_pc_out, .cpu_clear_out, .cfg_copy_req_out, .meas_start_out, .chip_reset_out,
	.activated_by_reset_out, .sleep_wake_flag_out, .wdt_count_out, .rtc_out, .status_out);

/* sim/cpu_partner.sv */
module cpu_partner (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic pc_load_in,
	input wire logic [11:0] pc_in,
	input wire logic cfg_req_in,
	input wire logic meas_start_in,
	input wire logic chip_reset_in,
	input wire logic do_clr_in,
	input wire logic [3:0] code_len_in,
	output logic cfg_done_out,
	output logic meas_done_out,
	output logic halt_out,
	output logic clrwdt_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] uc;
	logic [2:0] cc;
	logic [6:0] mc;

	// ==========
	// processor and measurement unit
	// measurement takes 80 cycles, far longer than user code, so wakes never pile up
	always @(posedge clk_sys_in) begin
		if (rst_in || chip_reset_in) begin
			{uc, cc, mc} <= '0;
			{cfg_done_out, meas_done_out, halt_out, clrwdt_out} <= '0;
		end else begin
			cfg_done_out <= cfg_req_in && cc == 3'h4 && !cfg_done_out;
			cc <= (cfg_req_in && !cfg_done_out) ? cc + 3'h1 : 3'h0;
			if (pc_load_in && pc_in == 12'h030)
				uc <= code_len_in;
			else if (uc != 4'h0)
				uc <= uc - 4'h1;
			clrwdt_out <= do_clr_in && uc == 4'h2;
			halt_out <= uc == 4'h1;
			mc <= meas_start_in ? 7'h50 : (mc != 7'h0 ? mc - 7'h1 : 7'h0);
			meas_done_out <= mc == 7'h1;
		end
	end
endmodule

/* sim/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic pin = 1'b1, host = 1'b1, slp = 1'b0, avz = 1'b0, uprg = 1'b1, off = 1'b0;
	logic tclr = 1'b0, kick = 1'b0, do_clr = 1'b1;
	logic [9:0] conv = 10'h3FF;
	logic [3:0] clen = 4'h3;
	logic run, pcl, cfgq, ms, cr, swf, cfgd, md, halt, cw;
	logic [11:0] pc;
	logic [2:0] wdt;
	logic [23:0] rtc, st;
	int mismatches = 0, n_tests = 0, cyc = 0, i, n;

	wake_reset_watchdog_sequencer #(.OSC_DIV_CYCLES(4)) dut (.clk_sys_in, .rst_in,
		.chip_select_reset_pin_in(pin), .host_port_enable_in(host), .sleep_mode_in(slp),
		.avrate_zero_in(avz), .conv_count_in(conv), .pwr_cfg_flag_in(1'b1),
		.pwr_prg_flag_in(1'b1), .usr_prg_flag_in(uprg), .cfg_copy_done_in(cfgd),
		.meas_done_in(md | kick), .cpu_halt_in(halt), .clrwdt_in(cw),
		.watchdog_off_cmd_in(off), .timer_clear_instr_in(tclr), .cpu_run_out(run),
		.cpu_pc_load_out(pcl), .cpu_pc_out(pc), .cpu_clear_out(), .cfg_copy_req_out(cfgq),
		.meas_start_out(ms), .chip_reset_out(cr), .osc_tick_out(),
		.activated_by_reset_out(), .sleep_wake_flag_out(swf), .wdt_count_out(wdt),
		.rtc_out(rtc), .status_out(st));

	cpu_partner cpu (.clk_sys_in, .rst_in, .pc_load_in(pcl), .pc_in(pc), .cfg_req_in(cfgq),
		.meas_start_in(ms), .chip_reset_in(cr), .do_clr_in(do_clr), .code_len_in(clen),
		.cfg_done_out(cfgd), .meas_done_out(md), .halt_out(halt), .clrwdt_out(cw));

	// ==========
	// helpers
	task automatic chk(input bit ok, input string m);
		n_tests++;
		if (!ok) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	task automatic end_of_test();
		$display("mismatches %0d checks %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge clk_sys_in);
	endtask

	// waits for one activation and follows it to the stop
	task automatic wake(input logic eu, input logic es);
		logic u, s;
		n = 0;
		u = 1'b0;
		s = 1'b0;
		while (!(pcl === 1'b1 && pc === 12'h800) && n < 3000) begin
			tick(1);
			n++;
		end
		while (run !== 1'b0 && n < 3000) begin
			s = swf === es && st[22] === es;
			if (pcl === 1'b1 && pc === 12'h030)
				u = 1'b1;
			tick(1);
			n++;
		end
		chk(n < 3000 && u === eu, "user start");
		chk(s, "sleep wake flag");
	endtask

	task automatic press(input logic h, input logic e);
		host = h;
		pin = 1'b0;
		n = 0;
		repeat (12) begin
			tick(1);
			if (cr === 1'b1)
				n = 1;
		end
		chk(n == int'(e), "pin reset");
		chk(st[18] === 1'b1, "button bit");
		pin = 1'b1;
		tick(40);
		host = 1'b1;
	endtask

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	initial begin
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	// ==========
	// scenarios
	initial begin
		void'($urandom(32'hC99B));
		tick(16);
		rst_in = 1'b0;
		wake(1'b1, 1'b0);
		for (i = 0; i < 2; i++) begin
			slp = i == 0;
			avz = i == 1;
			conv = 10'h001;
			wake(1'b1, 1'b1);
		end
		{slp, avz, conv} = {2'b00, 10'h3FF};
		press(1'b1, 1'b0);
		press(1'b0, 1'b1);
		tclr = 1'b1;
		tick(1);
		tclr = 1'b0;
		chk(rtc === 24'h0, "rtc clear");
		tick(1000);
		chk(rtc === 24'h2 || rtc === 24'h3, "rtc rate");
		// the measurement unit is restarted by a fresh kick after sleep
		for (i = 0; i < 8; i++) begin
			uprg = 1'($urandom);
			clen = 4'h2 + 4'($urandom % 8);
			kick = i == 0;
			tick(1);
			kick = 1'b0;
			wake(uprg, 1'b0);
			// a one-cycle pulse would be filtered by the pin synchroniser
			pin = 1'b0;
			tick(4);
			pin = 1'b1;
			tick(6);
			chk(wdt === 3'h0, "pin edge clear");
		end
		uprg = 1'b0;
		n = 0;
		while (cr !== 1'b1 && n < 2000) begin
			tick(1);
			n++;
		end
		chk(n < 2000 && st[17] === 1'b1, "watchdog alarm");
		tick(60);
		off = 1'b1;
		kick = 1'b1;
		tick(1);
		{off, kick} = 2'b00;
		n = 0;
		repeat (1500) begin
			tick(1);
			if (cr === 1'b1)
				n = 1;
		end
		chk(n == 0 && wdt === 3'h4, "watchdog off");
		end_of_test();
	end
endmodule
